// file: design/rtcc_top.sv
// Behaviour
// - Switchable divide-by-eight prescaler heads the chain
// - Reloadable 16-bit base timer follows prescaler
// - Four reloadable stages 10/6/6/10, two words
// - All stages count upwards only
// - Every stage requests; requests merge into one
// - System reset leaves counters and controls alone
// - Count clock passed through or divided by eight
// - Base timer overflow clocks the 32-bit chain
// - Slower system clock may miss count events
// - Stopped system clock stops synchronous counting
// - One mode bit: clear sync, set async
// - Async mode counts the same synchronised count clock edges
// - Async mode stops counting too when system clock stops
// - Async mode blocks counter and reload writes
// - Block reset: sync mode, prescaler enabled
// - Access flag reads one when full access
// - Add or drop one count pulse, self-clearing
// - Run bit enables counting, set by default
// - Soft reset restores counters and controls, then self-clears
// - Prescaler bit: zero undivided, one divided
`default_nettype none
module rtcc_top (
	input  wire logic                   ref_clk,
	input  wire logic                   rstn,
	input  wire logic                   por_n,
	input  wire logic                   count_clk,
	input  wire rtcc_pkg::rtcc_bus_req_t bus_req,
	output logic                 [15:0] rdata,
	output logic                  [4:0] stage_irq,
	output logic                        node_irq
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam int N = rtcc_pkg::NUM_STAGES;

	logic                 cnt_s1;
	logic                 cnt_s2;
	logic                 cnt_s3;
	logic                 next_cnt_s1;
	logic                 next_cnt_s2;
	logic                 next_cnt_s3;
	rtcc_pkg::rtcc_ctrl_t ctrl;
	rtcc_pkg::rtcc_ctrl_t next_ctrl;
	logic                 mode_sel;
	logic                 next_mode_sel;
	logic                 mode_eff;
	logic                 next_mode_eff;
	logic [1:0]           settle;
	logic [1:0]           next_settle;
	logic                 soft_pend;
	logic                 next_soft_pend;
	logic [2:0]           presc;
	logic [2:0]           next_presc;
	logic [15:0]          next_rdata;
	logic [4:0]           next_stage_irq;
	logic                 next_node_irq;
	logic                 block_clr;
	logic                 raw_evt;
	logic                 count_evt;
	logic                 base_evt;
	logic                 base_tick;
	logic                 base_double;
	logic                 access_flag;
	logic                 wr_open;
	logic [N-1:0]         tick;
	logic [N-1:0]         ovf;
	logic [N-1:0]         cnt_we;
	logic [N-1:0]         rel_we;
	logic [15:0]          cnt_wd [N];
	logic [15:0]          rel_wd [N];
	logic [15:0]          val [N];
	logic [15:0]          rel [N];

	function automatic logic wr_hit(input rtcc_pkg::rtcc_bus_req_t req, input logic [3:0] a);
		return req.wr && (req.addr == a);
	endfunction

	function automatic logic [15:0] field(input logic [15:0] word, input int lsb, input int w);
		return (word >> lsb) & ((16'(1) << w) - 16'(1));
	endfunction

	// ----------------------------------------------------------------
	// Count clock synchroniser and event detect
	// ----------------------------------------------------------------
	// Needs ref_clk at least four times count_clk; slower, edges are lost
	always_comb begin
		next_cnt_s1 = count_clk;
		next_cnt_s2 = cnt_s1;
		next_cnt_s3 = cnt_s2;
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cnt_s1 <= 1'b0;
			cnt_s2 <= 1'b0;
			cnt_s3 <= 1'b0;
		end else begin
			cnt_s1 <= next_cnt_s1;
			cnt_s2 <= next_cnt_s2;
			cnt_s3 <= next_cnt_s3;
		end
	end

	// Single-clock build: both modes take edges from the same sampled
	// count clock, so a halted ref_clk halts counting in either mode
	assign raw_evt   = cnt_s2 & ~cnt_s3;
	assign count_evt = raw_evt & ctrl.run;
	assign base_evt  = ctrl.pre ? (count_evt && presc == rtcc_pkg::PRESC_LAST) : count_evt;

	// Both correction bits together cancel out
	assign base_tick   = base_evt & ~(ctrl.dec & ~ctrl.inc);
	assign base_double = ctrl.inc & ~ctrl.dec;

	// ----------------------------------------------------------------
	// Control, mode and prescaler
	// ----------------------------------------------------------------
	assign block_clr   = ~por_n | soft_pend;
	assign access_flag = ~mode_eff;
	assign wr_open     = ~mode_sel & ~mode_eff;

	always_comb begin
		next_ctrl      = ctrl;
		next_mode_sel  = mode_sel;
		next_mode_eff  = mode_eff;
		next_settle    = settle;
		next_presc     = presc;
		next_soft_pend = 1'b0;
		if (block_clr) begin
			next_ctrl.run = rtcc_pkg::RUN_RST;
			next_ctrl.pre = rtcc_pkg::PRE_RST;
			next_ctrl.inc = 1'b0;
			next_ctrl.dec = 1'b0;
			next_mode_sel = rtcc_pkg::MODE_RST;
			next_mode_eff = rtcc_pkg::MODE_RST;
			next_settle   = '0;
			next_presc    = '0;
		end else begin
			if (ctrl.pre && count_evt)
				next_presc = presc + 3'h1;
			// Hardware clears a correction once done; a new write wins
			if (base_evt) begin
				next_ctrl.inc = 1'b0;
				next_ctrl.dec = 1'b0;
			end
			if (wr_hit(bus_req, rtcc_pkg::ADDR_CTRL)) begin
				next_ctrl.run = bus_req.wdata[rtcc_pkg::CTRL_RUN];
				next_ctrl.pre = bus_req.wdata[rtcc_pkg::CTRL_PRE];
				next_ctrl.inc = bus_req.wdata[rtcc_pkg::CTRL_INC] | next_ctrl.inc;
				next_ctrl.dec = bus_req.wdata[rtcc_pkg::CTRL_DEC] | next_ctrl.dec;
			end
			if (wr_hit(bus_req, rtcc_pkg::ADDR_SYS)) begin
				next_mode_sel  = bus_req.wdata[rtcc_pkg::SYS_MODE];
				next_soft_pend = bus_req.wdata[rtcc_pkg::SYS_SRST];
			end
			// Flag only moves once the new mode has settled
			if (mode_sel != mode_eff) begin
				next_settle = settle + 2'h1;
				if (settle == rtcc_pkg::MODE_SETTLE) begin
					next_mode_eff = mode_sel;
					next_settle   = '0;
				end
			end else begin
				next_settle = '0;
			end
		end
	end

	// Held across rstn: only por_n or the soft reset restore these
	always_ff @(posedge ref_clk) begin
		ctrl      <= next_ctrl;
		mode_sel  <= next_mode_sel;
		mode_eff  <= next_mode_eff;
		settle    <= next_settle;
		presc     <= next_presc;
		soft_pend <= next_soft_pend;
	end

	// ----------------------------------------------------------------
	// Write steering into the stages
	// ----------------------------------------------------------------
	always_comb begin
		cnt_we[0] = wr_open & wr_hit(bus_req, rtcc_pkg::ADDR_BASE);
		rel_we[0] = wr_open & wr_hit(bus_req, rtcc_pkg::ADDR_BASE_REL);
		cnt_we[1] = wr_open & wr_hit(bus_req, rtcc_pkg::ADDR_CHAIN_LOW);
		rel_we[1] = wr_open & wr_hit(bus_req, rtcc_pkg::ADDR_REL_LOW);
		cnt_we[2] = cnt_we[1];
		rel_we[2] = rel_we[1];
		cnt_we[3] = wr_open & wr_hit(bus_req, rtcc_pkg::ADDR_CHAIN_HIGH);
		rel_we[3] = wr_open & wr_hit(bus_req, rtcc_pkg::ADDR_REL_HIGH);
		cnt_we[4] = cnt_we[3];
		rel_we[4] = rel_we[3];
		cnt_wd[0] = bus_req.wdata;
		cnt_wd[1] = field(bus_req.wdata, 0, rtcc_pkg::stage_width(1));
		cnt_wd[2] = field(bus_req.wdata, rtcc_pkg::LOW_B_LSB, rtcc_pkg::stage_width(2));
		cnt_wd[3] = field(bus_req.wdata, 0, rtcc_pkg::stage_width(3));
		cnt_wd[4] = field(bus_req.wdata, rtcc_pkg::HIGH_D_LSB, rtcc_pkg::stage_width(4));
		for (int k = 0; k < N; k++)
			rel_wd[k] = cnt_wd[k];
	end

	// ----------------------------------------------------------------
	// Counter chain
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_stage
			if (i == 0) begin : g_head
				assign tick[i] = base_tick;
			end else begin : g_link
				assign tick[i] = ovf[i-1];
			end
			rtcc_stage #(
				.W (rtcc_pkg::stage_width(i))
			) u_stage (
				.ref_clk     (ref_clk),
				.clr         (block_clr),
				.tick        (tick[i]),
				.double_step ((i == 0) ? base_double : 1'b0),
				.cnt_we      (cnt_we[i]),
				.cnt_wd      (cnt_wd[i]),
				.rel_we      (rel_we[i]),
				.rel_wd      (rel_wd[i]),
				.value       (val[i]),
				.reload      (rel[i]),
				.ovf         (ovf[i])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read data and requests
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = 16'h0000;
		if (bus_req.rd) begin
			case (bus_req.addr)
				rtcc_pkg::ADDR_CTRL: begin
					next_rdata[rtcc_pkg::CTRL_ACC] = access_flag;
					next_rdata[rtcc_pkg::CTRL_INC] = ctrl.inc;
					next_rdata[rtcc_pkg::CTRL_DEC] = ctrl.dec;
					next_rdata[rtcc_pkg::CTRL_PRE] = ctrl.pre;
					next_rdata[rtcc_pkg::CTRL_RUN] = ctrl.run;
				end
				rtcc_pkg::ADDR_SYS:        next_rdata[rtcc_pkg::SYS_MODE] = mode_sel;
				rtcc_pkg::ADDR_BASE:       next_rdata = val[0];
				rtcc_pkg::ADDR_BASE_REL:   next_rdata = rel[0];
				rtcc_pkg::ADDR_CHAIN_LOW:  next_rdata = {val[2][5:0], val[1][9:0]};
				rtcc_pkg::ADDR_CHAIN_HIGH: next_rdata = {val[4][9:0], val[3][5:0]};
				rtcc_pkg::ADDR_REL_LOW:    next_rdata = {rel[2][5:0], rel[1][9:0]};
				rtcc_pkg::ADDR_REL_HIGH:   next_rdata = {rel[4][9:0], rel[3][5:0]};
				default:                   next_rdata = 16'h0000;
			endcase
		end
		next_stage_irq = ovf;
		next_node_irq  = |ovf;
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			rdata     <= 16'h0000;
			stage_irq <= 5'h00;
			node_irq  <= 1'b0;
		end else begin
			rdata     <= next_rdata;
			stage_irq <= next_stage_irq;
			node_irq  <= next_node_irq;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn || !por_n);

	presc_div_a: assert property (ctrl.pre && base_evt |-> count_evt && presc == rtcc_pkg::PRESC_LAST)
		else $error("divided tick without eighth event");
	bypass_a: assert property (!ctrl.pre && count_evt |-> base_evt)
		else $error("undivided event did not reach base timer");
	run_stop_a: assert property (!ctrl.run |-> !base_tick && !ovf[0])
		else $error("chain advanced while stopped");
	write_block_a: assert property (mode_eff && bus_req.wr && bus_req.addr == rtcc_pkg::ADDR_BASE
		&& !tick[0] && !soft_pend |=> $stable(val[0]))
		else $error("base timer written in async mode");
	irq_merge_a: assert property (|ovf |=> node_irq && stage_irq == $past(ovf))
		else $error("overflow request not merged");
	inc_clear_a: assert property (base_evt && !bus_req.wr |=> !ctrl.inc && !ctrl.dec)
		else $error("correction bit not cleared after count event");
	soft_rst_a: assert property (soft_pend |=> val[0] == 16'h0000 && ctrl.run && ctrl.pre && !mode_sel && access_flag)
		else $error("soft reset did not restore block");
	flag_settle_a: assert property ($rose(mode_sel) && !soft_pend |-> access_flag [*4] ##1 !access_flag)
		else $error("access flag did not follow settled mode");
	carry_a: assert property (ovf[0] && !base_double && !soft_pend |-> tick[1] ##1 val[0] == $past(rel[0]))
		else $error("base overflow did not reload and carry");
	hold_sysrst_a: assert property (@(posedge ref_clk) disable iff (!por_n)
		!rstn && !soft_pend && !tick[0] && !cnt_we[0] |=> val[0] == $past(val[0]) && ctrl == $past(ctrl))
		else $error("system reset disturbed counters");

	// ----------------------------------------------------------------
	// Stepping, ripple and flag checks
	// ----------------------------------------------------------------
	// Antecedents on block state skip the soft-reset cycle, which rewrites counters, reloads and controls
	count_up_a: assert property (tick[0] && !base_double && !ovf[0] && !soft_pend
		|=> val[0] == $past(val[0]) + 16'h0001)
		else $error("base timer did not step by one");
	add_pulse_a: assert property (tick[0] && base_double && !ovf[0] && !soft_pend
		|=> val[0] == $past(val[0]) + 16'h0002)
		else $error("added pulse not counted");
	drop_pulse_a: assert property (base_evt && ctrl.dec && !ctrl.inc && !cnt_we[0] && !soft_pend
		|=> $stable(val[0]))
		else $error("dropped pulse still counted");
	chain_step_a: assert property (tick[2] && !ovf[2] && !soft_pend
		|=> val[2] == $past(val[2]) + 16'h0001)
		else $error("chain stage did not step on carry");
	ripple_a: assert property (ovf[1] && !soft_pend
		|=> val[1] == $past(rel[1]))
		else $error("chain stage not reloaded on overflow");
	base_wr_a: assert property (wr_open && bus_req.wr && bus_req.addr == rtcc_pkg::ADDR_BASE
		&& !tick[0] && !soft_pend |=> val[0] == $past(bus_req.wdata))
		else $error("base timer write not taken");
	rel_block_a: assert property (mode_sel && bus_req.wr && bus_req.addr == rtcc_pkg::ADDR_REL_LOW
		&& !soft_pend |=> $stable(rel[1]) && $stable(rel[2]))
		else $error("reload written in async mode");
	pre_count_a: assert property (ctrl.pre && count_evt && !soft_pend
		|=> presc == $past(presc) + 3'h1)
		else $error("prescaler missed a count event");
	pre_hold_a: assert property (!ctrl.pre && !soft_pend
		|=> $stable(presc))
		else $error("prescaler moved while bypassed");
	flag_hold_a: assert property (mode_sel == mode_eff && !soft_pend
		|=> $stable(access_flag))
		else $error("access flag moved without mode change");
	flag_return_a: assert property ($fell(mode_sel) && mode_eff && !soft_pend
		|-> !access_flag [*4] ##1 access_flag)
		else $error("access flag did not return after settle");
	srst_self_a: assert property (soft_pend
		|=> !soft_pend)
		else $error("soft reset request did not clear");
	node_idle_a: assert property (ovf == 5'h00
		|=> !node_irq && stage_irq == 5'h00)
		else $error("request raised without overflow");
	rd_idle_a: assert property (!bus_req.rd
		|=> rdata == 16'h0000)
		else $error("read data shown without read strobe");

	base_ovf_c: cover property (ovf[0]);
	double_c:   cover property (base_tick && base_double);
	drop_c:     cover property (base_evt && !base_tick);
	async_c:    cover property (mode_eff && raw_evt);
	ripple_c:   cover property (ovf[4]);

endmodule
`default_nettype wire

// file: design/rtcc_pkg.sv
`default_nettype none
package rtcc_pkg;

	// ----------------------------------------------------------------
	// Register map (word index on the plain register port)
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL       = 4'h0;
	localparam logic [3:0] ADDR_SYS        = 4'h1;
	localparam logic [3:0] ADDR_BASE       = 4'h2;
	localparam logic [3:0] ADDR_BASE_REL   = 4'h3;
	localparam logic [3:0] ADDR_CHAIN_LOW  = 4'h4;
	localparam logic [3:0] ADDR_CHAIN_HIGH = 4'h5;
	localparam logic [3:0] ADDR_REL_LOW    = 4'h6;
	localparam logic [3:0] ADDR_REL_HIGH   = 4'h7;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_RUN = 0;
	localparam int CTRL_PRE = 1;
	localparam int CTRL_DEC = 2;
	localparam int CTRL_INC = 3;
	localparam int CTRL_ACC = 15;
	localparam int SYS_MODE = 0;
	localparam int SYS_SRST = 1;
	localparam int LOW_B_LSB  = 10;
	localparam int HIGH_D_LSB = 6;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic       RUN_RST    = 1'b1;
	localparam logic       PRE_RST    = 1'b1;
	localparam logic       MODE_RST   = 1'b0;
	localparam logic [2:0] PRESC_LAST = 3'h7;
	localparam logic [1:0] MODE_SETTLE = 2'h3;
	localparam int         NUM_STAGES = 5;

	function automatic int stage_width(input int idx);
		case (idx)
			0:       return 16;
			1:       return 10;
			2:       return 6;
			3:       return 6;
			default: return 10;
		endcase
	endfunction

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} rtcc_bus_req_t;

	typedef struct packed {
		logic inc;
		logic dec;
		logic pre;
		logic run;
	} rtcc_ctrl_t;

endpackage
`default_nettype wire

// file: design/rtcc_stage.sv
`default_nettype none
module rtcc_stage #(
	parameter int W = 16
) (
	input  wire logic        ref_clk,
	input  wire logic        clr,
	input  wire logic        tick,
	input  wire logic        double_step,
	input  wire logic        cnt_we,
	input  wire logic [15:0] cnt_wd,
	input  wire logic        rel_we,
	input  wire logic [15:0] rel_wd,
	output logic      [15:0] value,
	output logic      [15:0] reload,
	output logic             ovf
);

	localparam logic [W:0] STEP_ONE = (W+1)'(1);
	localparam logic [W:0] STEP_TWO = (W+1)'(2);

	logic [W-1:0] cnt;
	logic [W-1:0] rel;
	logic [W-1:0] next_cnt;
	logic [W-1:0] next_rel;
	logic [W:0]   sum;

	// Up-only step; the carry out of the top bit marks an overflow
	assign sum    = {1'b0, cnt} + (double_step ? STEP_TWO : STEP_ONE);
	assign ovf    = tick & sum[W];
	assign value  = 16'(cnt);
	assign reload = 16'(rel);

	always_comb begin
		next_cnt = cnt;
		next_rel = rel;
		if (clr) begin
			next_cnt = '0;
			next_rel = '0;
		end else begin
			if (rel_we)
				next_rel = rel_wd[W-1:0];
			// Counting beats a racing write so no time is lost
			if (tick) begin
				if (sum[W])
					next_cnt = rel + sum[W-1:0];
				else
					next_cnt = sum[W-1:0];
			end else if (cnt_we) begin
				next_cnt = cnt_wd[W-1:0];
			end
		end
	end

	// No system reset here: only the block clear touches the count
	always_ff @(posedge ref_clk) begin
		cnt <= next_cnt;
		rel <= next_rel;
	end

endmodule
`default_nettype wire

// file: testbench/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic                   ref_clk;
	logic                   rstn;
	logic                   por_n;
	logic                   count_clk;
	rtcc_pkg::rtcc_bus_req_t bus_req;
	logic            [15:0] rdata;
	logic             [4:0] stage_irq;
	logic                   node_irq;
	int                     num_errors;
	int                     samples_checked;

	typedef struct {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic [15:0] exp;
	} rtcc_row_t;

	rtcc_row_t rows [8];

	rtcc_top DUT (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.por_n     (por_n),
		.count_clk (count_clk),
		.bus_req   (bus_req),
		.rdata     (rdata),
		.stage_irq (stage_irq),
		.node_irq  (node_irq)
	);

	// ----------------------------------------------------------------
	// Clock and helpers
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic test_done();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk) bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge ref_clk) bus_req <= '0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge ref_clk) bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge ref_clk) bus_req <= '0;
		#1 d = rdata;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
		logic [15:0] d;
		rd(a, d);
		chk(d, exp);
	endtask

	// Each level held three system cycles, keeping the 4x margin
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge ref_clk) count_clk <= 1'b1;
			repeat (3) @(posedge ref_clk);
			count_clk <= 1'b0;
			repeat (2) @(posedge ref_clk);
		end
		repeat (6) @(posedge ref_clk);
	endtask

	task automatic ovf_case(input logic [15:0] lo, input logic [15:0] hi, input logic [4:0] irq,
		input logic [15:0] lo_exp, input logic [15:0] hi_exp);
		logic found;
		found = 1'b0;
		wr(rtcc_pkg::ADDR_BASE, 16'hFFFF);
		wr(rtcc_pkg::ADDR_CHAIN_LOW, lo);
		wr(rtcc_pkg::ADDR_CHAIN_HIGH, hi);
		@(posedge ref_clk) count_clk <= 1'b1;
		for (int i = 0; i < 20 && !found; i++) begin
			@(posedge ref_clk);
			#1 found = (node_irq === 1'b1);
		end
		chk({15'h0000, found}, 16'h0001);
		chk({11'h000, stage_irq}, {11'h000, irq});
		@(posedge ref_clk) count_clk <= 1'b0;
		#1 chk({10'h000, stage_irq, node_irq}, 16'h0000);
		rd_chk(rtcc_pkg::ADDR_BASE, 16'hFFFE);
		rd_chk(rtcc_pkg::ADDR_CHAIN_LOW, lo_exp);
		rd_chk(rtcc_pkg::ADDR_CHAIN_HIGH, hi_exp);
	endtask

	initial begin
		#200000;
		num_errors++;
		test_done();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		por_n = 1'b0;
		count_clk = 1'b0;
		bus_req = '0;
		num_errors = 0;
		samples_checked = 0;
		rows[0] = '{rtcc_pkg::ADDR_CTRL, 16'h0000, 16'h8000};
		rows[1] = '{rtcc_pkg::ADDR_BASE_REL, 16'hFFFF, 16'hFFFF};
		rows[2] = '{rtcc_pkg::ADDR_REL_LOW, 16'h1234, 16'h1234};
		rows[3] = '{rtcc_pkg::ADDR_REL_HIGH, 16'hABCD, 16'hABCD};
		rows[4] = '{rtcc_pkg::ADDR_BASE, 16'h0005, 16'h0005};
		rows[5] = '{rtcc_pkg::ADDR_CHAIN_LOW, 16'h5A5A, 16'h5A5A};
		rows[6] = '{rtcc_pkg::ADDR_CHAIN_HIGH, 16'h00FF, 16'h00FF};
		rows[7] = '{4'h8, 16'h1234, 16'h0000};
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		por_n <= 1'b1;
		rd_chk(rtcc_pkg::ADDR_CTRL, 16'h8003);
		// Read data must fall back to zero one cycle later
		@(posedge ref_clk);
		#1 chk(rdata, 16'h0000);
		rd_chk(rtcc_pkg::ADDR_SYS, 16'h0000);
		rd_chk(rtcc_pkg::ADDR_CHAIN_LOW, 16'h0000);
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			rd_chk(rows[i].addr, rows[i].exp);
		end
		// Soft reset restores defaults, then divide-by-eight is live
		wr(rtcc_pkg::ADDR_SYS, 16'h0002);
		repeat (3) @(posedge ref_clk);
		rd_chk(rtcc_pkg::ADDR_BASE, 16'h0000);
		rd_chk(rtcc_pkg::ADDR_REL_HIGH, 16'h0000);
		rd_chk(rtcc_pkg::ADDR_CTRL, 16'h8003);
		rd_chk(rtcc_pkg::ADDR_SYS, 16'h0000);
		pulse(16);
		rd_chk(rtcc_pkg::ADDR_BASE, 16'h0002);
		wr(rtcc_pkg::ADDR_CTRL, 16'h0001);
		pulse(5);
		rd_chk(rtcc_pkg::ADDR_BASE, 16'h0007);
		wr(rtcc_pkg::ADDR_CTRL, 16'h0000);
		pulse(4);
		rd_chk(rtcc_pkg::ADDR_BASE, 16'h0007);
		// Overflow ripple and merged requests
		wr(rtcc_pkg::ADDR_CTRL, 16'h0001);
		wr(rtcc_pkg::ADDR_BASE_REL, 16'hFFFE);
		ovf_case(16'h03FF, 16'h0000, 5'h03, 16'h0400, 16'h0000);
		ovf_case(16'hFFFF, 16'hFFFF, 5'h1F, 16'h0000, 16'h0000);
		// Pulse correction: add, drop, both
		wr(rtcc_pkg::ADDR_BASE, 16'h0010);
		wr(rtcc_pkg::ADDR_CTRL, 16'h0009);
		pulse(1);
		rd_chk(rtcc_pkg::ADDR_BASE, 16'h0012);
		rd_chk(rtcc_pkg::ADDR_CTRL, 16'h8001);
		wr(rtcc_pkg::ADDR_CTRL, 16'h0005);
		pulse(1);
		rd_chk(rtcc_pkg::ADDR_BASE, 16'h0012);
		pulse(1);
		rd_chk(rtcc_pkg::ADDR_BASE, 16'h0013);
		wr(rtcc_pkg::ADDR_CTRL, 16'h000D);
		pulse(1);
		rd_chk(rtcc_pkg::ADDR_BASE, 16'h0014);
		rd_chk(rtcc_pkg::ADDR_CTRL, 16'h8001);
		// Async mode: flag drops, writes refused, counting goes on
		wr(rtcc_pkg::ADDR_SYS, 16'h0001);
		repeat (8) @(posedge ref_clk);
		rd_chk(rtcc_pkg::ADDR_CTRL, 16'h0001);
		wr(rtcc_pkg::ADDR_BASE, 16'h0000);
		wr(rtcc_pkg::ADDR_REL_LOW, 16'h0055);
		rd_chk(rtcc_pkg::ADDR_BASE, 16'h0014);
		rd_chk(rtcc_pkg::ADDR_REL_LOW, 16'h0000);
		pulse(2);
		rd_chk(rtcc_pkg::ADDR_BASE, 16'h0016);
		rd_chk(rtcc_pkg::ADDR_BASE, 16'h0016);
		rd_chk(rtcc_pkg::ADDR_BASE, 16'h0016);
		wr(rtcc_pkg::ADDR_SYS, 16'h0000);
		repeat (8) @(posedge ref_clk);
		rd_chk(rtcc_pkg::ADDR_CTRL, 16'h8001);
		// System reset leaves timekeeping alone
		@(posedge ref_clk) rstn <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		rd_chk(rtcc_pkg::ADDR_BASE, 16'h0016);
		rd_chk(rtcc_pkg::ADDR_CTRL, 16'h8001);
		pulse(1);
		rd_chk(rtcc_pkg::ADDR_BASE, 16'h0017);
		test_done();
	end
endmodule
`default_nettype wire
